// ### hw/ascr_cfg.svh
`ifndef ASCR_CFG_SVH
`define ASCR_CFG_SVH

// Register byte addresses
`define ASCR_A_SECT_RATE   7'h13
`define ASCR_A_CLAMP_LO    7'h14
`define ASCR_A_CLAMP_MIX   7'h15
`define ASCR_A_CLAMP_HI    7'h16
`define ASCR_A_OFS0        7'h17
`define ASCR_A_OFS1        7'h18
`define ASCR_A_OFS_GAIN    7'h19
`define ASCR_A_GAIN_MID    7'h1A
`define ASCR_A_GAIN_KNEE   7'h1B
`define ASCR_A_KNEE_MID    7'h1C
`define ASCR_A_KNEE_TOP    7'h1D
`define ASCR_A_MAKER       7'h1E
`define ASCR_A_SIGNATURE   7'h1F
`define ASCR_A_PROC_CTRL   7'h23
`define ASCR_A_RAW_LO      7'h32
`define ASCR_A_RAW_HI      7'h33
`define ASCR_A_MAG         7'h34
`define ASCR_A_GCL         7'h35
`define ASCR_A_PROC_LO     7'h36
`define ASCR_A_PROC_HI     7'h37
`define ASCR_A_RATE_LO     7'h38
`define ASCR_A_RATE_HI     7'h39
`define ASCR_A_SAFE_LO     7'h3A
`define ASCR_A_SAFE_HI     7'h3B

// Configuration image span
`define ASCR_CFG_FIRST     7'h13
`define ASCR_CFG_LAST      7'h1E

// Writable masks of sparse bytes
`define ASCR_M_SECT_RATE   8'hF8
`define ASCR_M_KNEE_TOP    8'h9F
`define ASCR_M_PROC_CTRL   8'h60

// Field positions
`define ASCR_B_RATE_FILT   5
`define ASCR_B_EXT_DIS     3
`define ASCR_B_RED_RANGE   4
`define ASCR_B_LOCK        7
`define ASCR_B_DSP_RST     5
`define ASCR_B_FUSE_LOAD   6

// Reset values
`define ASCR_RST_BYTE      8'h00

`endif

// ### hw/ascr_pkg.sv
package ascr_pkg;

  typedef logic [7:0] ascr_byte_t;

  // Register access request from the link framer
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ascr_req_s;

  // Live results from the datapath
  typedef struct packed {
    logic [13:0] raw_angle;
    logic [7:0]  magnitude;
    logic [7:0]  gain_level;
    logic [11:0] proc_angle;
    logic [11:0] rate;
    logic [13:0] safety;
  } ascr_res_s;

  // Decoded configuration toward the datapath
  typedef struct packed {
    logic [1:0]  sector_sel;
    logic [2:0]  rate_filter;
    logic [11:0] upper_clamp_level;
    logic [11:0] lower_clamp_level;
    logic [19:0] offset;
    logic [16:0] gain;
    logic [13:0] transfer_knee_point;
    logic        ext_range_disable;
    logic        reduced_range;
    logic        customer_lock;
    logic [7:0]  maker_code;
  } ascr_cfg_s;

  typedef enum logic [1:0] {
    ASCR_RUN,
    ASCR_HOLD,
    ASCR_REFRESH
  } ascr_dsp_e;

endpackage : ascr_pkg

// ### hw/ascr_regs.sv
// Behaviour
// - Config byte 0x13 bits 7:5 select the rate filter.
// - Byte 0x1D bit 3 set disables the extended field range.
// - Byte 0x1D bit 4 set enables reduced angle range mode.
// - Byte 0x1F holds a signature over the whole configuration image.
// - Byte 0x23 bit 5 holds the signal processor in reset; read/write.
// - Raw 14-bit angle readable at 0x32 and 0x33 bits 5:0.
// - Processed 12-bit angle readable at 0x36 and 0x37 bits 3:0.
// - Byte 0x34 reads the field magnitude.
// - Byte 0x35 reads the gain control level.
// - 14-bit knee point spans 0x1B[7:5], 0x1C, 0x1D[2:0].
// - After processor reset the raw angle result is refreshed.
// - Programmed customer lock selects sensor output mode over supply pin.
`timescale 1ns/100ps
`default_nettype none
`include "ascr_cfg.svh"

module ascr_regs #(
  parameter int unsigned SIG_INIT = 8'h00
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // Register access
  input  wire ascr_pkg::ascr_req_s i_req,
  output logic [7:0]             o_rdata,
  output logic                   o_rvalid,
  // Datapath results
  input  wire logic              i_res_valid,
  input  wire ascr_pkg::ascr_res_s i_res,
  // Datapath control
  output var ascr_pkg::ascr_cfg_s o_cfg,
  output logic                   o_dsp_reset,
  output logic                   o_fuse_load_check,
  output logic                   o_output_mode,
  output logic [7:0]             o_signature
);

  localparam int unsigned CFG_N  = 12;
  localparam logic [7:0]  M_SECT = `ASCR_M_SECT_RATE;
  localparam logic [7:0]  M_KNEE = `ASCR_M_KNEE_TOP;
  localparam logic [7:0]  M_CTRL = `ASCR_M_PROC_CTRL;

  // Refuse header values that the fixed byte array cannot serve
  initial begin
    if (SIG_INIT > 255) begin
      $error("SIG_INIT must fit one byte");
    end
    if (`ASCR_CFG_LAST - `ASCR_CFG_FIRST + 1 != CFG_N) begin
      $error("configuration span must be twelve bytes");
    end
    if (`ASCR_A_SIGNATURE != `ASCR_CFG_LAST + 1) begin
      $error("signature byte must follow the image");
    end
    if (`ASCR_A_SECT_RATE != `ASCR_CFG_FIRST) begin
      $error("image must start at the sector byte");
    end
    if (`ASCR_A_MAKER != `ASCR_CFG_LAST) begin
      $error("image must end at the maker byte");
    end
    // Decode below reads the range byte at a fixed index
    if (`ASCR_A_KNEE_TOP - `ASCR_CFG_FIRST != 10) begin
      $error("range byte must sit at image index ten");
    end
    if (!M_SECT[`ASCR_B_RATE_FILT]) begin
      $error("rate filter field not writable");
    end
    if (!M_KNEE[`ASCR_B_EXT_DIS] || !M_KNEE[`ASCR_B_RED_RANGE]) begin
      $error("range option bits not writable");
    end
    if (!M_KNEE[`ASCR_B_LOCK]) begin
      $error("lock bit not writable");
    end
    if (!M_CTRL[`ASCR_B_DSP_RST] || !M_CTRL[`ASCR_B_FUSE_LOAD]) begin
      $error("control bits not writable");
    end
    // Multi-byte results keep the low half at the lower address
    if (`ASCR_A_RAW_HI != `ASCR_A_RAW_LO + 1) begin
      $error("raw angle bytes out of order");
    end
    if (`ASCR_A_PROC_HI != `ASCR_A_PROC_LO + 1) begin
      $error("processed angle bytes out of order");
    end
    if (`ASCR_A_RATE_HI != `ASCR_A_RATE_LO + 1) begin
      $error("rate bytes out of order");
    end
    if (`ASCR_A_SAFE_HI != `ASCR_A_SAFE_LO + 1) begin
      $error("safety bytes out of order");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Signature step over one image byte
  function automatic logic [7:0] sig_step(input logic [7:0] acc,
                                          input logic [7:0] b);
    logic [7:0] t;
    t = acc ^ b;
    sig_step = {t[6:0], t[7]} ^ {3'h0, t[7], t[7], t[7], 2'h0};
  endfunction : sig_step

  function automatic logic in_cfg(input logic [6:0] a);
    in_cfg = (a >= `ASCR_CFG_FIRST) && (a <= `ASCR_CFG_LAST);
  endfunction : in_cfg

  // Image byte index of a configuration address
  function automatic logic [3:0] cfg_idx(input logic [6:0] a);
    cfg_idx = 4'(a - `ASCR_CFG_FIRST);
  endfunction : cfg_idx

  ////////////////////////////////////////////////////////////////////////
  // Configuration image

  logic [7:0] cfg_r   [12];
  logic [7:0] cfg_nxt [12];
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [3:0] widx;

  always_comb begin
    widx = cfg_idx(i_req.addr);
    for (int i = 0; i < 12; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    ctrl_nxt = ctrl_r;
    if (i_req.wr && in_cfg(i_req.addr)) begin
      cfg_nxt[widx] = i_req.wdata;
      if (i_req.addr == `ASCR_A_SECT_RATE) begin
        cfg_nxt[widx] = i_req.wdata & `ASCR_M_SECT_RATE;
      end
      if (i_req.addr == `ASCR_A_KNEE_TOP) begin
        cfg_nxt[widx] = i_req.wdata & `ASCR_M_KNEE_TOP;
      end
    end
    if (i_req.wr && (i_req.addr == `ASCR_A_PROC_CTRL)) begin
      ctrl_nxt = i_req.wdata & `ASCR_M_PROC_CTRL;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 12; i++) begin
        cfg_r[i] <= `ASCR_RST_BYTE;
      end
      ctrl_r <= `ASCR_RST_BYTE;
    end else begin
      for (int i = 0; i < 12; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Signature

  logic [7:0] sig_r;
  logic [7:0] sig_nxt;

  // Built from next values so it follows a write at once
  // signature over image
  always_comb begin
    sig_nxt = 8'(SIG_INIT);
    for (int i = 0; i < 12; i++) begin
      sig_nxt = sig_step(sig_nxt, cfg_nxt[i]);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sig_r <= `ASCR_RST_BYTE;
    end else begin
      sig_r <= sig_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result capture

  ascr_pkg::ascr_dsp_e dsp_r;
  ascr_pkg::ascr_dsp_e dsp_nxt;
  ascr_pkg::ascr_res_s res_r;
  ascr_pkg::ascr_res_s res_nxt;

  // Results frozen while held, reloaded once released
  always_comb begin
    dsp_nxt = dsp_r;
    res_nxt = res_r;
    unique case (dsp_r)
      ascr_pkg::ASCR_RUN: begin
        if (ctrl_r[`ASCR_B_DSP_RST]) begin
          dsp_nxt = ascr_pkg::ASCR_HOLD;
        end else if (i_res_valid) begin
          res_nxt = i_res;
        end
      end
      ascr_pkg::ASCR_HOLD: begin
        if (!ctrl_r[`ASCR_B_DSP_RST]) begin
          if (i_res_valid) begin
            res_nxt = i_res;
            dsp_nxt = ascr_pkg::ASCR_RUN;
          end else begin
            dsp_nxt = ascr_pkg::ASCR_REFRESH;
          end
        end
      end
      ascr_pkg::ASCR_REFRESH: begin
        if (ctrl_r[`ASCR_B_DSP_RST]) begin
          dsp_nxt = ascr_pkg::ASCR_HOLD;
        end else if (i_res_valid) begin
          res_nxt = i_res;
          dsp_nxt = ascr_pkg::ASCR_RUN;
        end
      end
      // Fourth code of the state word is illegal
      default: begin
        dsp_nxt = ascr_pkg::ASCR_RUN;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dsp_r <= ascr_pkg::ASCR_RUN;
      res_r <= '0;
    end else begin
      dsp_r <= dsp_nxt;
      res_r <= res_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;

  // No latch between byte halves; a value may move between two reads
  // side-effect-free little-endian reads
  always_comb begin
    rvalid_nxt = i_req.rd;
    rdata_nxt  = 8'h00;
    if (i_req.rd) begin
      if (in_cfg(i_req.addr)) begin
        rdata_nxt = cfg_r[cfg_idx(i_req.addr)];
      end
      unique case (i_req.addr)
        `ASCR_A_SIGNATURE: rdata_nxt = sig_r;
        `ASCR_A_PROC_CTRL: rdata_nxt = ctrl_r;
        `ASCR_A_RAW_LO:    rdata_nxt = res_r.raw_angle[7:0];
        `ASCR_A_RAW_HI:    rdata_nxt = {2'h0, res_r.raw_angle[13:8]};
        `ASCR_A_MAG:       rdata_nxt = res_r.magnitude;
        `ASCR_A_GCL:       rdata_nxt = res_r.gain_level;
        `ASCR_A_PROC_LO:   rdata_nxt = res_r.proc_angle[7:0];
        `ASCR_A_PROC_HI:   rdata_nxt = {4'h0, res_r.proc_angle[11:8]};
        `ASCR_A_RATE_LO:   rdata_nxt = res_r.rate[7:0];
        `ASCR_A_RATE_HI:   rdata_nxt = {4'h0, res_r.rate[11:8]};
        `ASCR_A_SAFE_LO:   rdata_nxt = res_r.safety[7:0];
        `ASCR_A_SAFE_HI:   rdata_nxt = {2'h0, res_r.safety[13:8]};
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded outputs

  ascr_pkg::ascr_cfg_s cfg_out_r;
  ascr_pkg::ascr_cfg_s cfg_out_nxt;
  logic [2:0]          ctl_out_r;
  logic [2:0]          ctl_out_nxt;

  always_comb begin
    cfg_out_nxt.sector_sel  = cfg_nxt[0][4:3];
    cfg_out_nxt.rate_filter = cfg_nxt[0][7:`ASCR_B_RATE_FILT];
    cfg_out_nxt.upper_clamp_level = {cfg_nxt[2][3:0], cfg_nxt[1]};
    cfg_out_nxt.lower_clamp_level = {cfg_nxt[3], cfg_nxt[2][7:4]};
    cfg_out_nxt.offset = {cfg_nxt[6][3:0], cfg_nxt[5], cfg_nxt[4]};
    cfg_out_nxt.gain   = {cfg_nxt[8][4:0], cfg_nxt[7], cfg_nxt[6][7:4]};
    cfg_out_nxt.transfer_knee_point =
      {cfg_nxt[10][2:0], cfg_nxt[9], cfg_nxt[8][7:5]};
    cfg_out_nxt.ext_range_disable = cfg_nxt[10][`ASCR_B_EXT_DIS];
    cfg_out_nxt.reduced_range = cfg_nxt[10][`ASCR_B_RED_RANGE];
    cfg_out_nxt.customer_lock = cfg_nxt[10][`ASCR_B_LOCK];
    cfg_out_nxt.maker_code    = cfg_nxt[11];
    ctl_out_nxt[0] = ctrl_nxt[`ASCR_B_DSP_RST];
    ctl_out_nxt[1] = ctrl_nxt[`ASCR_B_FUSE_LOAD];
    ctl_out_nxt[2] = cfg_nxt[10][`ASCR_B_LOCK];
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_out_r <= '0;
      ctl_out_r <= 3'h0;
    end else begin
      cfg_out_r <= cfg_out_nxt;
      ctl_out_r <= ctl_out_nxt;
    end
  end

  assign o_rdata           = rdata_r;
  assign o_rvalid          = rvalid_r;
  assign o_cfg             = cfg_out_r;
  assign o_dsp_reset       = ctl_out_r[0];
  assign o_fuse_load_check = ctl_out_r[1];
  assign o_output_mode     = ctl_out_r[2];
  assign o_signature       = sig_r;

endmodule : ascr_regs
`default_nettype wire

// ### test/ascr_chk_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ascr_chk (
  // Clock and reset
  input wire logic                i_sys_clk,
  input wire logic                i_rst_n,
  // Watched ports
  input wire ascr_pkg::ascr_req_s i_req,
  input wire logic [7:0]          o_rdata,
  input wire logic                o_rvalid,
  input wire ascr_pkg::ascr_cfg_s o_cfg,
  input wire logic                o_dsp_reset,
  input wire logic                o_fuse_load_check,
  input wire logic                o_output_mode
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire w13 = i_req.wr && i_req.addr == 7'h13;
  wire w1c = i_req.wr && i_req.addr == 7'h1C;
  wire w1d = i_req.wr && i_req.addr == 7'h1D;
  wire w23 = i_req.wr && i_req.addr == 7'h23;
  wire run = i_req.rd && !(i_req.addr inside
    {[7'h13:7'h1F], 7'h23, [7'h32:7'h3B]});
  property p_filt;
    w13 |=> o_cfg.rate_filter == $past(i_req.wdata[7:5]);
  endproperty
  a_filt: assert property (p_filt) else $error("filter field");
  property p_ext;
    w1d |=> o_cfg.ext_range_disable == $past(i_req.wdata[3]);
  endproperty
  a_ext: assert property (p_ext) else $error("range disable");
  property p_red;
    w1d |=> o_cfg.reduced_range == $past(i_req.wdata[4]);
  endproperty
  a_red: assert property (p_red) else $error("reduced range");
  property p_dsp;
    w23 |=> o_dsp_reset == $past(i_req.wdata[5]);
  endproperty
  a_dsp: assert property (p_dsp) else $error("dsp reset bit");
  property p_fuse;
    w23 |=> o_fuse_load_check == $past(i_req.wdata[6]);
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse load bit");
  property p_knee;
    w1c |=> o_cfg.transfer_knee_point[10:3] == $past(i_req.wdata);
  endproperty
  a_knee: assert property (p_knee) else $error("knee byte");
  property p_lock;
    w1d |=> o_output_mode == $past(i_req.wdata[7]);
  endproperty
  a_lock: assert property (p_lock) else $error("output mode");
  property p_keep;
    !w1d |=> $stable(o_output_mode);
  endproperty
  a_keep: assert property (p_keep) else $error("mode changed");
  property p_unm;
    run |=> o_rvalid && o_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_raw;
    i_req.rd && i_req.addr == 7'h33 |=> o_rdata[7:6] == 2'h0;
  endproperty
  a_raw: assert property (p_raw) else $error("raw high bits");
endmodule : ascr_chk
bind ascr_regs ascr_chk ascr_chk_i (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_req(i_req), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .o_cfg(o_cfg), .o_dsp_reset(o_dsp_reset),
  .o_fuse_load_check(o_fuse_load_check), .o_output_mode(o_output_mode));
`default_nettype wire

// ### test/ascr_dp_model.sv
`timescale 1ns/100ps
`default_nettype none
module ascr_dp_model (
  // Clock and reset
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst_n,
  // Pace select
  input  wire logic           i_slow,
  // Result samples
  output logic                o_res_valid,
  output var ascr_pkg::ascr_res_s o_res
);
  logic [3:0] cnt;
  // Samples move every cycle, so a stale capture shows
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 4'h0;
      o_res_valid <= 1'b0;
      o_res <= 68'h1;
    end else begin
      cnt <= (cnt >= (i_slow ? 4'h6 : 4'h2)) ? 4'h0 : cnt + 4'h1;
      o_res_valid <= cnt == 4'h0;
      o_res <= {o_res[66:0], o_res[67] ^ o_res[58]} ^ {64'h0, cnt};
    end
  end
endmodule : ascr_dp_model
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_sys_clk = 0, i_rst_n = 0, slow = 0, rv, rvalid, dspr, fl, om;
  logic [7:0] rdata, sig, img [128], e;
  logic [31:0] rng = 32'h5350;
  ascr_pkg::ascr_req_s req = '0;
  ascr_pkg::ascr_res_s res, cap = '0, old = '0;
  ascr_pkg::ascr_cfg_s cfg;
  int errors = 0, total_checks = 0, st = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  ascr_regs ascr_regs_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid), .i_res_valid(rv),
    .i_res(res), .o_cfg(cfg), .o_dsp_reset(dspr),
    .o_fuse_load_check(fl), .o_output_mode(om), .o_signature(sig));
  ascr_dp_model ascr_dp_model_i (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_slow(slow), .o_res_valid(rv), .o_res(res));
  ////////////////////////////////////////////////////////////////
  // capture frozen while held, refreshed after release
  always @(posedge i_sys_clk) if (i_rst_n) begin
    old = cap;
    if (rv && st != 1) begin cap = res; st = 0; end
    if (req.wr && req.addr == 7'h23)
      st = req.wdata[5] ? 1 : (st == 1 ? 2 : st);
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13); rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5); return rng;
  endfunction : xs
  function automatic logic [7:0] msk(logic [6:0] a);
    if (a == 7'h13) return 8'hF8;
    if (a == 7'h1D) return 8'h9F;
    if (a == 7'h23) return 8'h60;
    return (a >= 7'h14 && a <= 7'h1E) ? 8'hFF : 8'h00;
  endfunction : msk
  function automatic logic [7:0] sg();
    logic [7:0] acc, t;
    acc = 8'h00;
    for (int a = 8'h13; a <= 8'h1E; a++) begin
      t = acc ^ img[a];
      acc = {t[6:0], t[7]} ^ (t[7] ? 8'h1C : 8'h00);
    end
    return acc;
  endfunction : sg
  task automatic chkc();
    ascr_pkg::ascr_cfg_s x;
    x = {img[19][4:3], img[19][7:5], img[21][3:0], img[20], img[22],
         img[21][7:4], img[25][3:0], img[24], img[23], img[27][4:0],
         img[26], img[25][7:4], img[29][2:0], img[28], img[27][7:5],
         img[29][3], img[29][4], img[29][7], img[30]};
    for (int j = 0; j < 12; j++)
      chk(8'(cfg >> (8 * j)), 8'(x >> (8 * j)));
  endtask : chkc
  function automatic logic [7:0] ev(logic [6:0] a);
    case (a)
      7'h32: return old.raw_angle[7:0];
      7'h33: return {2'h0, old.raw_angle[13:8]};
      7'h34: return old.magnitude;
      7'h35: return old.gain_level;
      7'h36: return old.proc_angle[7:0];
      7'h37: return {4'h0, old.proc_angle[11:8]};
      7'h38: return old.rate[7:0];
      7'h39: return {4'h0, old.rate[11:8]};
      7'h3A: return old.safety[7:0];
      7'h3B: return {2'h0, old.safety[13:8]};
      7'h1F: return sg();
      default: return msk(a) != 8'h00 ? img[a] : 8'h00;
    endcase
  endfunction : ev
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) #1 req = {2'b10, a, d};
    img[a] = d & msk(a);
    @(posedge i_sys_clk) #1 req = '0;
  endtask : wr
  task automatic rd(input logic [6:0] a);
    @(posedge i_sys_clk) #1 req = {2'b01, a, 8'h00};
    @(posedge i_sys_clk) #1 req = '0;
    e = ev(a);
    chk({7'h0, rvalid}, 8'h01);
    chk(rdata, e);
  endtask : rd
  task automatic rd_res();
    for (int a = 8'h32; a <= 8'h3B; a++) rd(7'(a));
  endtask : rd_res
  task automatic conclude();
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    errors++;
    conclude();
  end
  initial begin
    for (int i = 0; i < 128; i++) img[i] = 8'h00;
    repeat (5) @(posedge i_sys_clk);
    #1 i_rst_n = 1;
    for (int a = 8'h13; a <= 8'h23; a++) rd(7'(a));
    for (int i = 0; i < 39; i++) begin
      e = 8'(xs());
      wr(i % 13 == 12 ? 7'h23 : 7'(8'h13 + i % 13), e);
      rd(i % 13 == 12 ? 7'h23 : 7'(8'h13 + i % 13));
      chk(cfg.transfer_knee_point[7:0], {img[28][4:0], img[27][7:5]});
      chk({2'h0, cfg.transfer_knee_point[13:8]},
          {2'h0, img[29][2:0], img[28][7:5]});
      chk({2'h0, cfg.rate_filter, cfg.ext_range_disable,
           cfg.reduced_range, om},
          {2'h0, img[19][7:5], img[29][3], img[29][4], img[29][7]});
      chk({6'h0, dspr, fl}, {6'h0, img[35][5], img[35][6]});
      chk(sig, sg());
      rd(7'h1F);
      chkc();
    end
    wr(7'h23, 8'hFF);
    rd(7'h23);
    wr(7'h23, 8'h40);
    chk({7'h0, fl}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      wr(7'h23, 8'h20);
      rd_res();
      repeat (9) @(posedge i_sys_clk);
      rd_res();
      wr(7'h23, 8'h00);
      repeat (9) @(posedge i_sys_clk);
      rd_res();
    end
    wr(7'h32, 8'hFF);
    rd(7'h32);
    foreach (img[i]) if (i % 37 == 0) rd(7'(i));
    rd(7'h3C);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
